/* File: verilog/pme_consts.svh */
// pme_consts.svh: offsets, field positions and reset values of the pme router
// assumes: included by bare name from the package and both ends
`ifndef PME_CONSTS_SVH
`define PME_CONSTS_SVH
`define PME_OFF_ROOT_CTRL 8'h1C
`define PME_OFF_ROOT_STATUS 8'h20
`define PME_OFF_MISC_PORT_CONFIG 8'hD8
`define PME_OFF_PM_CTRL_STATUS 8'hDC
`define PME_OFF_GPE_STATUS 8'hE0
`define PME_OFF_GPE_ENABLE 8'hE4
`define PME_BIT_INT_EN 3
`define PME_BIT_RS_STATUS 16
`define PME_BIT_SCI_ROUTE 31
`define PME_BIT_SMI_ROUTE 0
`define PME_BIT_POWER_MGMT_CTRL_STATUS_STATUS 31
`define PME_BIT_POWER_MGMT_CTRL_STATUS_EN 8
`define PME_BIT_GPE_PCIE 17
`define PME_REQ_ID_W 16
`define PME_RESET_WORD 32'h0000_0000
`endif

/* File: verilog/pme_pkg.sv */
// pme_pkg.sv: types shared by both ends of the pme router
// assumes: pme_consts.svh is on the include path
package pme_pkg;
  `include "pme_consts.svh"
  typedef logic [`PME_REQ_ID_W-1:0] req_id_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0] cfg_addr_t;
  typedef enum logic [1:0] {ROUTE_NATIVE, ROUTE_SCI, ROUTE_SMI} route_t;
endpackage

/* File: verilog/pme_if.sv */
// pme_if.sv: config-access and pme-message link between host and root port
// assumes: single clock; host is the only master of the config accesses
`timescale 1ns/1ps
interface pme_if;
  logic msg_valid;
  pme_pkg::req_id_t msg_req_id;
  logic cfg_wr;
  logic cfg_rd;
  pme_pkg::cfg_addr_t cfg_addr;
  pme_pkg::word_t cfg_wdata;
  pme_pkg::word_t cfg_rdata;
  logic cfg_ack;
  logic pme_irq;
  logic sci;
  logic smi;
  modport dev (input msg_valid, msg_req_id, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    output cfg_rdata, cfg_ack, pme_irq, sci, smi);
  modport host (output msg_valid, msg_req_id, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    input cfg_rdata, cfg_ack, pme_irq, sci, smi);
endinterface

/* File: verilog/root_port_pme_event_router.sv */
// root_port_pme_event_router.sv: root port pme status, routing and gpe block
// assumes: pme messages arrive as one-cycle pulses on the ref clock
`timescale 1ns/1ps
`include "pme_consts.svh"
module root_port_pme_event_router (
  input wire logic i_ref_clk, // 40 mhz clock
  input wire logic i_rstn, // async reset, active low
  pme_if.dev lnk, // message and config link
  output logic o_route_sci // sci route currently selected
);
  // no wake input is provided at this port
  // root status flag, held id and one pending message
  logic rs_stat_r;
  logic rs_stat_nxt;
  logic pend_r;
  logic pend_nxt;
  pme_pkg::req_id_t req_id_r;
  pme_pkg::req_id_t req_id_nxt;
  pme_pkg::req_id_t pend_id_r;
  pme_pkg::req_id_t pend_id_nxt;
  // enables and route selects written by the host
  logic int_en_r;
  logic int_en_nxt;
  logic sci_route_r;
  logic sci_route_nxt;
  logic smi_route_r;
  logic smi_route_nxt;
  // pm status, pm enable and gpe bit 17 pair
  logic power_mgmt_ctrl_status_stat_r;
  logic power_mgmt_ctrl_status_stat_nxt;
  logic power_mgmt_ctrl_status_en_r;
  logic power_mgmt_ctrl_status_en_nxt;
  logic gpe_stat_r;
  logic gpe_stat_nxt;
  logic gpe_en_r;
  logic gpe_en_nxt;
  // bus answer and event outputs, all flops
  pme_pkg::word_t rdata_r;
  pme_pkg::word_t rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  logic irq_r;
  logic irq_nxt;
  logic sci_r;
  logic sci_nxt;
  logic smi_r;
  logic smi_nxt;
  logic route_r;
  logic route_nxt;
  // decoded strobes of this cycle
  logic wr_rs;
  logic wr_dc;
  logic wr_ge;
  logic msg;
  logic clr_rs;

  always_comb begin
    wr_rs = lnk.cfg_wr && (lnk.cfg_addr == `PME_OFF_ROOT_STATUS);
    wr_dc = lnk.cfg_wr && (lnk.cfg_addr == `PME_OFF_PM_CTRL_STATUS);
    wr_ge = lnk.cfg_wr && (lnk.cfg_addr == `PME_OFF_GPE_STATUS);
    msg = lnk.msg_valid;
    clr_rs = wr_rs && lnk.cfg_wdata[`PME_BIT_RS_STATUS];
    rs_stat_nxt = rs_stat_r;
    req_id_nxt = req_id_r;
    pend_nxt = pend_r;
    pend_id_nxt = pend_id_r;
    power_mgmt_ctrl_status_stat_nxt = power_mgmt_ctrl_status_stat_r;
    gpe_stat_nxt = gpe_stat_r;
    int_en_nxt = int_en_r;
    sci_route_nxt = sci_route_r;
    smi_route_nxt = smi_route_r;
    power_mgmt_ctrl_status_en_nxt = power_mgmt_ctrl_status_en_r;
    gpe_en_nxt = gpe_en_r;
    if (clr_rs) begin
      rs_stat_nxt = 1'b0;
    end
    // a message held back while the flag was set is reloaded on clear
    if (clr_rs && pend_r) begin
      rs_stat_nxt = 1'b1;
      req_id_nxt = pend_id_r;
      pend_nxt = 1'b0;
    end
    if (msg) begin
      if (!rs_stat_r || (clr_rs && !pend_r)) begin
        rs_stat_nxt = 1'b1;
        req_id_nxt = lnk.msg_req_id;
      end else begin
        pend_nxt = 1'b1;
        pend_id_nxt = lnk.msg_req_id;
      end
    end
    if (wr_dc && lnk.cfg_wdata[`PME_BIT_POWER_MGMT_CTRL_STATUS_STATUS]) begin
      power_mgmt_ctrl_status_stat_nxt = 1'b0;
    end
    if (msg && power_mgmt_ctrl_status_en_r) begin
      power_mgmt_ctrl_status_stat_nxt = 1'b1;
    end
    if (wr_ge && lnk.cfg_wdata[`PME_BIT_GPE_PCIE]) begin
      gpe_stat_nxt = 1'b0;
    end
    if (msg && sci_route_r) begin
      gpe_stat_nxt = 1'b1;
    end
    if (lnk.cfg_wr) begin
      if (lnk.cfg_addr == `PME_OFF_ROOT_CTRL) begin
        int_en_nxt = lnk.cfg_wdata[`PME_BIT_INT_EN];
      end else if (lnk.cfg_addr == `PME_OFF_MISC_PORT_CONFIG) begin
        sci_route_nxt = lnk.cfg_wdata[`PME_BIT_SCI_ROUTE];
        smi_route_nxt = lnk.cfg_wdata[`PME_BIT_SMI_ROUTE];
      end else if (lnk.cfg_addr == `PME_OFF_PM_CTRL_STATUS) begin
        power_mgmt_ctrl_status_en_nxt = lnk.cfg_wdata[`PME_BIT_POWER_MGMT_CTRL_STATUS_EN];
      end else if (lnk.cfg_addr == `PME_OFF_GPE_ENABLE) begin
        gpe_en_nxt = lnk.cfg_wdata[`PME_BIT_GPE_PCIE];
      end
    end
  end

  always_comb begin
    ack_nxt = lnk.cfg_rd || lnk.cfg_wr;
    rdata_nxt = `PME_RESET_WORD;
    if (lnk.cfg_rd) begin
      if (lnk.cfg_addr == `PME_OFF_ROOT_STATUS) begin
        rdata_nxt[`PME_REQ_ID_W-1:0] = req_id_r;
        rdata_nxt[`PME_BIT_RS_STATUS] = rs_stat_r;
        rdata_nxt[`PME_BIT_RS_STATUS+1] = pend_r;
      end else if (lnk.cfg_addr == `PME_OFF_ROOT_CTRL) begin
        rdata_nxt[`PME_BIT_INT_EN] = int_en_r;
      end else if (lnk.cfg_addr == `PME_OFF_MISC_PORT_CONFIG) begin
        rdata_nxt[`PME_BIT_SCI_ROUTE] = sci_route_r;
        rdata_nxt[`PME_BIT_SMI_ROUTE] = smi_route_r;
      end else if (lnk.cfg_addr == `PME_OFF_PM_CTRL_STATUS) begin
        rdata_nxt[`PME_BIT_POWER_MGMT_CTRL_STATUS_STATUS] = power_mgmt_ctrl_status_stat_r;
        rdata_nxt[`PME_BIT_POWER_MGMT_CTRL_STATUS_EN] = power_mgmt_ctrl_status_en_r;
      end else if (lnk.cfg_addr == `PME_OFF_GPE_STATUS) begin
        rdata_nxt[`PME_BIT_GPE_PCIE] = gpe_stat_r;
      end else if (lnk.cfg_addr == `PME_OFF_GPE_ENABLE) begin
        rdata_nxt[`PME_BIT_GPE_PCIE] = gpe_en_r;
      end
    end
    // native only while sci route is off
    irq_nxt = int_en_nxt && rs_stat_nxt && !sci_route_nxt;
    sci_nxt = gpe_stat_nxt && gpe_en_nxt;
    smi_nxt = smi_route_nxt && rs_stat_nxt;
    route_nxt = sci_route_nxt;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rs_stat_r <= 1'b0;
      pend_r <= 1'b0;
      req_id_r <= '0;
      pend_id_r <= '0;
      int_en_r <= 1'b0;
      sci_route_r <= 1'b0;
      smi_route_r <= 1'b0;
      power_mgmt_ctrl_status_stat_r <= 1'b0;
      power_mgmt_ctrl_status_en_r <= 1'b0;
      gpe_stat_r <= 1'b0;
      gpe_en_r <= 1'b0;
      rdata_r <= `PME_RESET_WORD;
      ack_r <= 1'b0;
      irq_r <= 1'b0;
      sci_r <= 1'b0;
      smi_r <= 1'b0;
      route_r <= 1'b0;
    end else begin
      rs_stat_r <= rs_stat_nxt;
      pend_r <= pend_nxt;
      req_id_r <= req_id_nxt;
      pend_id_r <= pend_id_nxt;
      int_en_r <= int_en_nxt;
      sci_route_r <= sci_route_nxt;
      smi_route_r <= smi_route_nxt;
      power_mgmt_ctrl_status_stat_r <= power_mgmt_ctrl_status_stat_nxt;
      power_mgmt_ctrl_status_en_r <= power_mgmt_ctrl_status_en_nxt;
      gpe_stat_r <= gpe_stat_nxt;
      gpe_en_r <= gpe_en_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      irq_r <= irq_nxt;
      sci_r <= sci_nxt;
      smi_r <= smi_nxt;
      route_r <= route_nxt;
    end
  end

  assign lnk.cfg_rdata = rdata_r;
  assign lnk.cfg_ack = ack_r;
  assign lnk.pme_irq = irq_r;
  assign lnk.sci = sci_r;
  assign lnk.smi = smi_r;
  assign o_route_sci = route_r;
endmodule // root_port_pme_event_router

/* File: verilog/pme_host_agent.sv */
// pme_host_agent.sv: host side; config sequencer and pme message source
// assumes: device answers each config access with cfg_ack one cycle later
`timescale 1ns/1ps
`include "pme_consts.svh"
module pme_host_agent (
  input wire logic i_ref_clk, // 40 mhz clock
  input wire logic i_rstn, // async reset, active low
  pme_if.host lnk, // link to root port
  input wire logic i_msg, // send one pme message (pulse)
  input wire pme_pkg::req_id_t i_msg_id, // requester id of that message
  input wire logic i_sel_native, // set up native route (pulse)
  input wire logic i_sel_sci, // set up sci route (pulse)
  output logic o_busy, // sequence running
  output pme_pkg::req_id_t o_last_id, // id seen by the last handler
  output logic o_handled // handler finished (pulse)
);
  typedef enum {S_IDLE, S_WR, S_WAIT, S_RD_RS, S_CHK} st_t;
  typedef enum {J_NATIVE, J_SCI, J_HANDLE} job_t;
  st_t st_r, st_nxt;
  job_t job_r, job_nxt;
  logic [3:0] step_r, step_nxt;
  logic msg_r, msg_nxt;
  pme_pkg::req_id_t mid_r, mid_nxt, last_r, last_nxt;
  logic wr_r, wr_nxt, rd_r, rd_nxt, done_r, done_nxt, busy_r, busy_nxt;
  pme_pkg::cfg_addr_t a_r, a_nxt;
  pme_pkg::word_t d_r, d_nxt;

  always_comb begin
    st_nxt = st_r;
    job_nxt = job_r;
    step_nxt = step_r;
    a_nxt = a_r;
    d_nxt = d_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    done_nxt = 1'b0;
    last_nxt = last_r;
    msg_nxt = i_msg;
    mid_nxt = i_msg_id;
    case (st_r)
      S_IDLE: begin
        step_nxt = 4'h0;
        if (i_sel_native) begin
          job_nxt = J_NATIVE;
          st_nxt = S_WR;
        end else if (i_sel_sci) begin
          job_nxt = J_SCI;
          st_nxt = S_WR;
        end else if (lnk.sci || lnk.pme_irq) begin
          job_nxt = J_HANDLE;
          st_nxt = S_WR;
        end
      end
      S_WR: begin
        wr_nxt = 1'b1;
        st_nxt = S_WAIT;
        d_nxt = '0;
        case (job_r)
          J_NATIVE: begin
            if (step_r == 4'h0) begin
              a_nxt = `PME_OFF_MISC_PORT_CONFIG;
            end else if (step_r == 4'h1) begin
              a_nxt = `PME_OFF_PM_CTRL_STATUS;
              d_nxt[`PME_BIT_POWER_MGMT_CTRL_STATUS_EN] = 1'b1;
            end else begin
              a_nxt = `PME_OFF_ROOT_CTRL;
              d_nxt[`PME_BIT_INT_EN] = 1'b1;
            end
          end
          J_SCI: begin
            if (step_r == 4'h0) begin
              a_nxt = `PME_OFF_ROOT_CTRL;
            end else if (step_r == 4'h1) begin
              a_nxt = `PME_OFF_GPE_STATUS;
              d_nxt[`PME_BIT_GPE_PCIE] = 1'b1;
            end else if (step_r == 4'h2) begin
              a_nxt = `PME_OFF_MISC_PORT_CONFIG;
              d_nxt[`PME_BIT_SCI_ROUTE] = 1'b1;
            end else if (step_r == 4'h3) begin
              a_nxt = `PME_OFF_PM_CTRL_STATUS;
              d_nxt[`PME_BIT_POWER_MGMT_CTRL_STATUS_EN] = 1'b1;
            end else begin
              a_nxt = `PME_OFF_GPE_ENABLE;
              d_nxt[`PME_BIT_GPE_PCIE] = 1'b1;
            end
          end
          default: begin
            if (step_r == 4'h0) begin
              a_nxt = `PME_OFF_GPE_ENABLE;
            end else if (step_r == 4'h1) begin
              a_nxt = `PME_OFF_ROOT_STATUS;
              d_nxt[`PME_BIT_RS_STATUS] = 1'b1;
            end else if (step_r == 4'h2) begin
              a_nxt = `PME_OFF_PM_CTRL_STATUS;
              d_nxt[`PME_BIT_POWER_MGMT_CTRL_STATUS_STATUS] = 1'b1;
              d_nxt[`PME_BIT_POWER_MGMT_CTRL_STATUS_EN] = 1'b1;
            end else if (step_r == 4'h3) begin
              a_nxt = `PME_OFF_GPE_STATUS;
              d_nxt[`PME_BIT_GPE_PCIE] = 1'b1;
            end else begin
              a_nxt = `PME_OFF_GPE_ENABLE;
              d_nxt[`PME_BIT_GPE_PCIE] = 1'b1;
            end
          end
        endcase
      end
      S_WAIT: begin
        if (lnk.cfg_ack) begin
          step_nxt = step_r + 4'h1;
          st_nxt = S_WR;
          if (job_r == J_HANDLE && step_r == 4'h0) begin
            st_nxt = S_RD_RS;
            step_nxt = step_r;
          end else if (job_r == J_HANDLE && step_r == 4'h1) begin
            st_nxt = S_RD_RS; // re-check after clear
          end else if ((job_r == J_NATIVE && step_r == 4'h2)
              || (job_r != J_NATIVE && step_r == 4'h4)) begin
            st_nxt = S_IDLE;
            done_nxt = (job_r == J_HANDLE);
          end
        end
      end
      S_RD_RS: begin
        rd_nxt = 1'b1;
        a_nxt = `PME_OFF_ROOT_STATUS;
        st_nxt = S_CHK;
      end
      S_CHK: begin
        if (lnk.cfg_ack) begin
          st_nxt = S_WR;
          if (lnk.cfg_rdata[`PME_BIT_RS_STATUS]) begin
            last_nxt = lnk.cfg_rdata[`PME_REQ_ID_W-1:0];
            step_nxt = 4'h1;
          end else begin
            step_nxt = 4'h2;
          end
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    busy_nxt = (st_nxt != S_IDLE);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= S_IDLE;
      job_r <= J_NATIVE;
      step_r <= 4'h0;
      msg_r <= 1'b0;
      mid_r <= '0;
      last_r <= '0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      a_r <= 8'h00;
      d_r <= `PME_RESET_WORD;
    end else begin
      st_r <= st_nxt;
      job_r <= job_nxt;
      step_r <= step_nxt;
      msg_r <= msg_nxt;
      mid_r <= mid_nxt;
      last_r <= last_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
    end
  end

  assign lnk.msg_valid = msg_r;
  assign lnk.msg_req_id = mid_r;
  assign lnk.cfg_wr = wr_r;
  assign lnk.cfg_rd = rd_r;
  assign lnk.cfg_addr = a_r;
  assign lnk.cfg_wdata = d_r;
  assign o_busy = busy_r;
  assign o_last_id = last_r;
  assign o_handled = done_r;
endmodule // pme_host_agent

/* File: sim/pme_link_properties.sv */
// pme_link_properties.sv: checker of the pme link between host agent and root port
// assumes: instanced beside the link interface; one clock, async active-low reset
`timescale 1ns/1ps
module pme_link_checker (
  input wire logic i_ref_clk, // ref clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_msg_valid, // pme message
  input wire logic i_cfg_wr, // write strobe
  input wire logic i_cfg_rd, // read strobe
  input wire pme_pkg::cfg_addr_t i_cfg_addr, // config offset
  input wire pme_pkg::word_t i_cfg_wdata, // write data
  input wire pme_pkg::word_t i_cfg_rdata, // read data
  input wire logic i_cfg_ack, // access answer
  input wire logic i_pme_irq, // native interrupt
  input wire logic i_sci, // sci request
  input wire logic i_smi // smi request
);
  `include "pme_consts.svh"
  logic int_en_r, int_en_nxt, route_r, route_nxt, gpe_en_r, gpe_en_nxt;
  logic smi_en_r, smi_en_nxt, pm_en_r, pm_en_nxt;
  // shadow of the enables as written by the host
  always_comb begin
    int_en_nxt = int_en_r;
    route_nxt = route_r;
    gpe_en_nxt = gpe_en_r;
    smi_en_nxt = smi_en_r;
    pm_en_nxt = pm_en_r;
    if (i_cfg_wr) begin
      case (i_cfg_addr)
        `PME_OFF_ROOT_CTRL: int_en_nxt = i_cfg_wdata[`PME_BIT_INT_EN];
        `PME_OFF_MISC_PORT_CONFIG: begin
          route_nxt = i_cfg_wdata[`PME_BIT_SCI_ROUTE];
          smi_en_nxt = i_cfg_wdata[`PME_BIT_SMI_ROUTE];
        end
        `PME_OFF_PM_CTRL_STATUS: pm_en_nxt = i_cfg_wdata[`PME_BIT_POWER_MGMT_CTRL_STATUS_EN];
        `PME_OFF_GPE_ENABLE: gpe_en_nxt = i_cfg_wdata[`PME_BIT_GPE_PCIE];
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {int_en_r, route_r, gpe_en_r, smi_en_r, pm_en_r} <= 5'h00;
    end else begin
      {int_en_r, route_r, gpe_en_r, smi_en_r, pm_en_r} <=
        {int_en_nxt, route_nxt, gpe_en_nxt, smi_en_nxt, pm_en_nxt};
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  ack_follows_a: assert property ((i_cfg_wr || i_cfg_rd) |=> i_cfg_ack)
    else $error("config access not acked next cycle");
  ack_cause_a: assert property (i_cfg_ack |-> $past(i_cfg_wr || i_cfg_rd))
    else $error("ack without access");
  rdata_idle_a: assert property (!i_cfg_ack |-> i_cfg_rdata == 32'h0000_0000)
    else $error("read data outside ack");
  status_word_a: assert property (
    i_cfg_ack && $past(i_cfg_rd && i_cfg_addr == 8'h20) |-> i_cfg_rdata[31:18] == 14'h0000)
    else $error("root status upper bits set");
  irq_raise_a: assert property (
    i_msg_valid && int_en_r && !route_r && !i_cfg_wr |=> i_pme_irq)
    else $error("message did not raise native interrupt");
  irq_gate_a: assert property (i_pme_irq |-> int_en_r || $past(int_en_r))
    else $error("native interrupt while disabled");
  sci_raise_a: assert property (
    i_msg_valid && route_r && gpe_en_r && pm_en_r && !i_cfg_wr |=> i_sci)
    else $error("message did not raise sci");
  sci_gate_a: assert property (i_sci |-> gpe_en_r || $past(gpe_en_r))
    else $error("sci while gpe enable clear");
  smi_quiet_a: assert property (!smi_en_r && !$past(smi_en_r) |-> !i_smi)
    else $error("smi while smi route off");
  level_hold_a: assert property (
    $fell(i_pme_irq) || $fell(i_sci) |-> $past(i_cfg_wr))
    else $error("event level dropped without a write");
  native_order_a: assert property ($rose(int_en_r) |-> !route_r)
    else $error("native interrupt enabled while sci route on");
  sci_order_a: assert property ($rose(route_r) |-> !int_en_r)
    else $error("sci route enabled while native interrupt on");
  cover property (i_pme_irq ##1 !i_pme_irq);
  cover property (i_sci ##1 !i_sci);
  cover property (i_msg_valid ##2 i_msg_valid);
endmodule // pme_link_checker

/* File: sim/tb_root_port_pme_event_router.sv */
// tb_root_port_pme_event_router.sv: bench joining host agent and root port
// assumes: design files compiled first; host agent runs the handler itself
`timescale 1ns/1ps
module tb_root_port_pme_event_router;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_msg = 1'b0;
  pme_pkg::req_id_t i_msg_id = 16'h0000;
  logic i_sel_native = 1'b0;
  logic i_sel_sci = 1'b0;
  logic o_busy, o_handled, o_route_sci;
  pme_pkg::req_id_t o_last_id;
  logic irq_seen = 1'b0;
  logic sci_seen = 1'b0;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  pme_if lnk ();
  root_port_pme_event_router u_root_port_pme_event_router (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .lnk(lnk), .o_route_sci(o_route_sci));
  pme_host_agent u_pme_host_agent (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .lnk(lnk),
    .i_msg(i_msg), .i_msg_id(i_msg_id), .i_sel_native(i_sel_native), .i_sel_sci(i_sel_sci),
    .o_busy(o_busy), .o_last_id(o_last_id), .o_handled(o_handled));
  pme_link_checker u_pme_link_checker (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_msg_valid(lnk.msg_valid), .i_cfg_wr(lnk.cfg_wr), .i_cfg_rd(lnk.cfg_rd),
    .i_cfg_addr(lnk.cfg_addr), .i_cfg_wdata(lnk.cfg_wdata), .i_cfg_rdata(lnk.cfg_rdata),
    .i_cfg_ack(lnk.cfg_ack), .i_pme_irq(lnk.pme_irq), .i_sci(lnk.sci), .i_smi(lnk.smi));
  initial begin
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic step();
    @(posedge i_ref_clk);
    #2;
  endtask
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cmp_id(input string name, input pme_pkg::req_id_t exp,
    input pme_pkg::req_id_t got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(ref logic sig);
    step();
    sig = 1'b1;
    step();
    sig = 1'b0;
  endtask
  task automatic send(input pme_pkg::req_id_t id);
    step();
    i_msg_id = id;
    i_msg = 1'b1;
    step();
    i_msg = 1'b0;
  endtask
  // bounded wait for idle (0) or handler done (1), noting raised events
  task automatic wait_for(input bit done_kind);
    int n;
    n = 0;
    while (n < 300 && (done_kind ? o_handled !== 1'b1 : o_busy !== 1'b0)) begin
      step();
      n++;
      if (lnk.pme_irq === 1'b1) irq_seen = 1'b1;
      if (lnk.sci === 1'b1) sci_seen = 1'b1;
    end
    cmp_bit("wait done", 1'b1, n < 300);
  endtask
  task automatic check_idle();
    cmp_bit("idle irq", 1'b0, lnk.pme_irq);
    cmp_bit("idle sci", 1'b0, lnk.sci);
    cmp_bit("idle smi", 1'b0, lnk.smi);
    cmp_bit("idle route", 1'b0, o_route_sci);
    cmp_bit("idle busy", 1'b0, o_busy);
  endtask
  task automatic run_route(input logic to_sci, input pme_pkg::req_id_t id);
    if (to_sci) pulse(i_sel_sci);
    else pulse(i_sel_native);
    wait_for(1'b0);
    cmp_bit("route sci", to_sci, o_route_sci);
    irq_seen = 1'b0;
    sci_seen = 1'b0;
    send(id);
    wait_for(1'b1);
    cmp_bit("irq raised", !to_sci, irq_seen);
    cmp_bit("sci raised", to_sci, sci_seen);
    cmp_id("handler id", id, o_last_id);
    step();
    cmp_bit("irq after", 1'b0, lnk.pme_irq);
    cmp_bit("sci after", 1'b0, lnk.sci);
    cmp_bit("smi off", 1'b0, lnk.smi);
  endtask
  task automatic back_to_back();
    irq_seen = 1'b0;
    send(16'h00A0);
    send(16'h00B0);
    wait_for(1'b1);
    cmp_bit("pair irq", 1'b1, irq_seen);
    cmp_id("pair id", 16'h00B0, o_last_id);
    repeat (3) step();
    cmp_bit("pair cleared", 1'b0, lnk.pme_irq);
  endtask
  task automatic reset_mid();
    send(16'h1234);
    step();
    i_rstn = 1'b0;
    step();
    check_idle();
    i_rstn = 1'b1;
    run_route(1'b0, 16'h8000);
  endtask
  initial begin
    repeat (4) step();
    i_rstn = 1'b1;
    check_idle();
    run_route(1'b0, 16'h0A51);
    run_route(1'b1, 16'hFFFF);
    run_route(1'b0, 16'h0001);
    back_to_back();
    reset_mid();
    report_and_stop();
  end
endmodule // tb_root_port_pme_event_router
